// ===== ascl_loader.sv
// Active serial configuration loader: sequencer, flash link and APB registers
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module ascl_loader
  import ascl_pkg::*;
#(
  parameter int POR_STD = POR_STD_CYCLES,
  parameter int POR_FAST = POR_FAST_CYCLES,
  parameter int RESTART = RESTART_CYCLES,
  parameter int INIT_OSC = INIT_OSC_CYCLES,
  parameter int USER_INIT = USER_INIT_CYCLES
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Straps and control pins
  input wire logic i_por_delay_select,
  input wire logic i_weak_pullup_disable,
  input wire logic [2:0] i_scheme_select,
  input wire logic i_config_request_n,
  input wire logic i_user_startup_clock,
  input wire logic i_chain_enable_in_n,
  output logic o_chain_enable_out_n,
  // Open-drain status lines
  input wire logic i_config_status_n,
  output logic o_config_status_n,
  output logic o_config_status_n_oe,
  input wire logic i_config_complete,
  output logic o_config_complete,
  output logic o_config_complete_oe,
  input wire logic i_init_complete,
  output logic o_init_complete,
  output logic o_init_complete_oe,
  // Flash link
  output logic o_cfg_serial_clock,
  output logic o_cfg_serial_clock_oe,
  output logic o_flash_chip_select_n,
  output logic o_flash_chip_select_n_oe,
  output logic o_cfg_command_out,
  output logic o_cfg_command_out_oe,
  input wire logic i_cfg_serial_data_in,
  // Configuration memory and user I/O control
  output logic [31:0] o_cfg_word,
  output logic o_cfg_word_valid,
  output logic o_user_io_oe,
  output logic o_weak_pullup_en,
  output logic o_user_mode
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic por_sel, wpd, req_n, stat_in, done_in, uclk, chain_in_n, din;
  logic [2:0] scheme;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {i_por_delay_select, i_weak_pullup_disable, i_config_request_n,
                i_config_status_n, i_config_complete, i_user_startup_clock,
                i_chain_enable_in_n, i_cfg_serial_data_in, i_scheme_select};
      sync2 <= sync1;
    end
  end

  assign {por_sel, wpd, req_n, stat_in, done_in, uclk, chain_in_n, din, scheme} = sync2;

  // ****************************************************************
  // Registers
  // ****************************************************************
  ascl_state_t state;
  logic [3:0] ctrl;
  logic [31:0] words;
  logic [23:0] start_addr;
  logic error_flag;
  logic [31:0] rx_words;
  logic set_error;
  logic wr_en;
  logic rd_ok;

  assign o_pready = 1'b1;
  assign wr_en = i_psel && i_penable && i_pwrite;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_CTRL) || (a == REG_WORDS) || (a == REG_ADDR) ||
             (a == REG_STATUS) || (a == REG_RXCNT);
  endfunction : mapped

  assign rd_ok = mapped(i_paddr);
  assign o_pslverr = i_psel && i_penable && !rd_ok;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctrl <= CTRL_RESET;
      words <= DEFAULT_WORDS;
      start_addr <= ADDR_RESET;
    end
    else if (wr_en)
    begin
      if (i_paddr == REG_CTRL)
        ctrl <= i_pwdata[3:0];
      if (i_paddr == REG_WORDS)
        words <= i_pwdata;
      if (i_paddr == REG_ADDR)
        start_addr <= i_pwdata[23:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      error_flag <= 1'b0;
    else if (set_error)
      error_flag <= 1'b1;
    else if (wr_en && i_paddr == REG_STATUS && i_pwdata[STAT_ERROR])
      error_flag <= 1'b0;
  end

  always_comb
  begin
    o_prdata = 32'h00000000;
    case (i_paddr)
      REG_CTRL: o_prdata = {28'h0000000, ctrl};
      REG_WORDS: o_prdata = words;
      REG_ADDR: o_prdata = {8'h00, start_addr};
      REG_STATUS: o_prdata = {27'h0000000, o_user_mode, error_flag, state};
      REG_RXCNT: o_prdata = rx_words;
      default: o_prdata = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Serial clock divider
  // ****************************************************************
  logic [1:0] div;
  logic fall_en;
  logic div_run;

  // 125 MHz has no exact 40 MHz divide, so the link runs slower, never faster
  assign div_run = (state == ST_CMD) || (state == ST_DATA) || (state == ST_INIT);
  assign fall_en = div_run && (div == 2'(SCLK_DIV / 2 - 1));

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      div <= 2'h0;
    else if (!div_run)
      div <= 2'h0;
    else
      div <= (div == 2'(SCLK_DIV - 1)) ? 2'h0 : div + 2'h1;
  end

  // ****************************************************************
  // Request filter and user clock edge
  // ****************************************************************
  logic [8:0] req_cnt;
  logic req_hold;
  logic uclk_d;
  logic uclk_rise;

  assign req_hold = (req_cnt == 9'(REQ_MIN_CYCLES));
  assign uclk_rise = uclk && !uclk_d;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      req_cnt <= 9'h000;
    else if (req_n)
      req_cnt <= 9'h000;
    else if (!req_hold)
      req_cnt <= req_cnt + 9'h001;
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      uclk_d <= 1'b0;
    else
      uclk_d <= uclk;
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic [31:0] cnt;
  logic [31:0] ushift;
  logic skip;
  logic [4:0] bitpos;
  logic [31:0] cmd_sh;
  logic frame0;
  logic word_done;
  logic parity_bad;
  logic uphase;
  logic start_ok;

  assign word_done = (state == ST_DATA) && fall_en && !skip && (bitpos == 5'h1f);
  assign parity_bad = ^{ushift[30:0], din};
  // Only the active serial master drives the flash; chain input gates start
  assign start_ok = req_n && stat_in && !chain_in_n && (scheme == ACTIVE_SERIAL_SCHEME);
  assign set_error = word_done && parity_bad;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= ST_POR;
      cnt <= 32'h00000000;
      skip <= 1'b0;
      bitpos <= 5'h00;
      cmd_sh <= 32'h00000000;
      ushift <= 32'h00000000;
      rx_words <= 32'h00000000;
      frame0 <= 1'b0;
      uphase <= 1'b0;
    end
    else if (state != ST_POR && state != ST_ERROR && (req_hold || !stat_in)
             && !(state == ST_RESET))
    begin
      state <= ST_RESET;
      frame0 <= 1'b0;
    end
    else
    begin
      case (state)
        ST_POR:
        begin
          cnt <= cnt + 32'h00000001;
          if (cnt >= 32'(por_sel ? POR_FAST : POR_STD) - 32'h00000001)
          begin
            state <= ST_RESET;
            cnt <= 32'h00000000;
          end
        end
        ST_RESET:
        begin
          frame0 <= 1'b0;
          rx_words <= 32'h00000000;
          if (start_ok)
          begin
            state <= ST_CMD;
            cmd_sh <= {READ_CMD, start_addr};
            cnt <= 32'h00000000;
          end
        end
        ST_CMD:
        begin
          if (fall_en)
          begin
            cnt <= cnt + 32'h00000001;
            if (cnt != 32'h00000000)
              cmd_sh <= {cmd_sh[30:0], 1'b0};
            if (cnt == 32'(CMD_BITS - 1))
            begin
              state <= ST_DATA;
              skip <= 1'b1;
              bitpos <= 5'h00;
            end
          end
        end
        ST_DATA:
        begin
          if (fall_en)
          begin
            if (skip)
              skip <= 1'b0;
            else
            begin
              ushift <= {ushift[30:0], din};
              bitpos <= bitpos + 5'h01;
            end
          end
          if (word_done)
          begin
            frame0 <= 1'b1;
            rx_words <= rx_words + 32'h00000001;
            if (parity_bad)
            begin
              state <= ST_ERROR;
              cnt <= 32'h00000000;
            end
            else if (rx_words + 32'h00000001 >= words)
              state <= ST_WAIT_DONE;
          end
        end
        ST_WAIT_DONE:
        begin
          if (done_in)
          begin
            state <= ST_INIT;
            cnt <= 32'h00000000;
            uphase <= 1'b0;
          end
        end
        ST_INIT:
        begin
          if (!ctrl[CTRL_USER_CLK])
          begin
            cnt <= cnt + 32'h00000001;
            if (cnt >= 32'(INIT_OSC) - 32'h00000001)
              state <= ST_USER;
          end
          else if (!uphase)
          begin
            if (fall_en)
              cnt <= cnt + 32'h00000001;
            if (fall_en && cnt == 32'(USER_CLK_DELAY_SCLKS - 1))
            begin
              uphase <= 1'b1;
              cnt <= 32'h00000000;
            end
          end
          else if (uclk_rise)
          begin
            cnt <= cnt + 32'h00000001;
            if (cnt == 32'(USER_INIT) - 32'h00000001)
              state <= ST_USER;
          end
        end
        ST_USER:
          state <= ST_USER;
        ST_ERROR:
        begin
          cnt <= cnt + 32'h00000001;
          // A held request restarts even while the auto-restart timer runs
          if (req_hold)
            state <= ST_RESET;
          else if (ctrl[CTRL_AUTO_RESTART] && cnt >= 32'(RESTART) - 32'h00000001)
            state <= ST_RESET;
        end
        default:
          state <= ST_POR;
      endcase
    end
  end

  // ****************************************************************
  // Configuration memory load with zero-run expansion
  // ****************************************************************
  logic [ZRUN_BITS-1:0] zrun;
  logic load_word;

  assign load_word = word_done && !parity_bad;

  // A run marker expands to zero words; runs stay shorter than one word time
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      zrun <= '0;
      o_cfg_word <= 32'h00000000;
      o_cfg_word_valid <= 1'b0;
    end
    else if (load_word && ctrl[CTRL_COMPRESSED] && ushift[30])
    begin
      zrun <= {ushift[ZRUN_BITS-2:0], din};
      o_cfg_word_valid <= 1'b0;
    end
    else if (load_word)
    begin
      o_cfg_word <= {ushift[30:0], din};
      o_cfg_word_valid <= 1'b1;
    end
    else if (zrun != '0)
    begin
      zrun <= zrun - {{(ZRUN_BITS-1){1'b0}}, 1'b1};
      o_cfg_word <= 32'h00000000;
      o_cfg_word_valid <= 1'b1;
    end
    else
      o_cfg_word_valid <= 1'b0;
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic link_on;

  assign link_on = (state == ST_CMD) || (state == ST_DATA);

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_config_status_n_oe <= 1'b1;
      o_config_complete_oe <= 1'b1;
      o_init_complete_oe <= 1'b0;
      o_cfg_serial_clock <= 1'b1;
      o_cfg_serial_clock_oe <= 1'b0;
      o_flash_chip_select_n <= 1'b1;
      o_flash_chip_select_n_oe <= 1'b0;
      o_cfg_command_out <= 1'b1;
      o_cfg_command_out_oe <= 1'b0;
      o_chain_enable_out_n <= 1'b1;
      o_user_io_oe <= 1'b0;
      o_weak_pullup_en <= 1'b0;
      o_user_mode <= 1'b0;
    end
    else
    begin
      o_config_status_n_oe <= (state == ST_POR) || (state == ST_ERROR) ||
                              (state == ST_RESET && !req_n);
      o_config_complete_oe <= (state != ST_WAIT_DONE) && (state != ST_INIT) &&
                              (state != ST_USER);
      o_init_complete_oe <= ctrl[CTRL_INIT_DONE_EN] && frame0 &&
                            (state != ST_USER) && (state != ST_RESET);
      o_cfg_serial_clock <= link_on ? (div >= 2'(SCLK_DIV / 2) ? 1'b0 : 1'b1) : 1'b1;
      o_cfg_serial_clock_oe <= link_on;
      o_flash_chip_select_n <= !link_on;
      o_flash_chip_select_n_oe <= link_on || (state == ST_ERROR);
      // Last command bit must stand until the flash samples it on the next rise
      o_cfg_command_out <= ((state == ST_CMD) || (state == ST_DATA && skip)) ? cmd_sh[31] :
                           1'b1;
      o_cfg_command_out_oe <= link_on;
      o_chain_enable_out_n <= !((state == ST_WAIT_DONE) || (state == ST_INIT) ||
                                (state == ST_USER));
      o_user_io_oe <= (state == ST_USER);
      o_weak_pullup_en <= !wpd && (state != ST_POR) && (state != ST_USER);
      o_user_mode <= (state == ST_USER);
    end
  end

  assign o_config_status_n = 1'b0;
  assign o_config_complete = 1'b0;
  assign o_init_complete = 1'b0;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_last_word;
    word_done && !parity_bad && (rx_words + 32'h00000001 >= words);
  endsequence

  sequence s_released;
    !o_config_complete_oe && !o_cfg_serial_clock_oe && !o_chain_enable_out_n;
  endsequence

  property p_done_release;
    @(posedge i_clock) disable iff (i_reset) s_last_word |=> ##1 s_released;
  endproperty
  a_done_release: assert property (p_done_release)
    else $error("complete or serial pins not released after last word");

  property p_por_hold;
    @(posedge i_clock) disable iff (i_reset)
      (state == ST_POR) |=> o_config_status_n_oe && o_config_complete_oe && !o_user_io_oe;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("status or complete not held low in power-on");

  property p_fall_spacing;
    @(posedge i_clock) disable iff (i_reset) fall_en |=> !fall_en [*3];
  endproperty
  a_fall_spacing: assert property (p_fall_spacing)
    else $error("serial clock falls closer than one period");

  property p_cmd_stable;
    @(posedge i_clock) disable iff (i_reset)
      (state == ST_CMD) && !fall_en && $past(state == ST_CMD) |=> $stable(cmd_sh);
  endproperty
  a_cmd_stable: assert property (p_cmd_stable)
    else $error("command bit changed away from a falling edge");

  property p_select_low;
    @(posedge i_clock) disable iff (i_reset)
      link_on |=> !o_flash_chip_select_n && o_flash_chip_select_n_oe;
  endproperty
  a_select_low: assert property (p_select_low)
    else $error("flash not selected during configuration");

  property p_error_drive;
    @(posedge i_clock) disable iff (i_reset)
      set_error |=> (state == ST_ERROR) ##1 o_config_status_n_oe && o_config_complete_oe;
  endproperty
  a_error_drive: assert property (p_error_drive)
    else $error("frame error not shown on status");

  // Age of the current error stay; the time-out is too long for a delay range
  logic [16:0] err_age;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      err_age <= 17'h00000;
    else if (state == ST_ERROR)
      err_age <= err_age + 17'h00001;
    else
      err_age <= 17'h00000;
  end

  property p_restart;
    @(posedge i_clock) disable iff (i_reset)
      (state == ST_ERROR) && ctrl[CTRL_AUTO_RESTART] |-> (err_age < 17'(RESTART));
  endproperty
  a_restart: assert property (p_restart)
    else $error("auto-restart did not release status in time");

  property p_request;
    @(posedge i_clock) disable iff (i_reset)
      req_hold && (state != ST_POR) && !req_n ##1 !req_n |=>
        (state == ST_RESET) && o_config_status_n_oe;
  endproperty
  a_request: assert property (p_request)
    else $error("held request did not reset the sequencer");

  property p_user_io;
    @(posedge i_clock) disable iff (i_reset)
      (state == ST_USER) |=> o_user_io_oe && !o_weak_pullup_en && !o_init_complete_oe;
  endproperty
  a_user_io: assert property (p_user_io)
    else $error("user mode without released pins");

endmodule : ascl_loader

// ===== ascl_pkg.sv
// Constants, register map and state encoding of the serial configuration loader
package ascl_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int POR_STD_MS = 100;
  localparam int POR_FAST_MS = 4;
  localparam int POR_STD_CYCLES = POR_STD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_FAST_CYCLES = POR_FAST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RESTART_US = 500;
  localparam int RESTART_CYCLES = RESTART_US * 1000 / CLK_PERIOD_NS;
  localparam int REQ_MIN_US = 2;
  localparam int REQ_MIN_CYCLES = (REQ_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_PERIOD_NS = 25;
  localparam int SCLK_DIV = (SCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_OSC_US = 55;
  localparam int INIT_OSC_CYCLES = INIT_OSC_US * 1000 / CLK_PERIOD_NS;
  localparam int USER_CLK_DELAY_SCLKS = 4;
  localparam int USER_INIT_CYCLES = 8532;

  // ****************************************************************
  // Flash command and scheme codes
  // ****************************************************************
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam int CMD_BITS = 32;
  localparam int WORD_BITS = 32;
  localparam logic [2:0] ACTIVE_SERIAL_SCHEME = 3'h2;
  localparam logic [31:0] DEFAULT_WORDS = 32'h00000100;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WORDS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RXCNT = 8'h10;
  localparam int CTRL_AUTO_RESTART = 0;
  localparam int CTRL_USER_CLK = 1;
  localparam int CTRL_INIT_DONE_EN = 2;
  localparam int CTRL_COMPRESSED = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam int STAT_ERROR = 3;
  localparam int STAT_USER = 4;
  localparam int ZRUN_BITS = 6;

  // ****************************************************************
  // Sequencer states, Gray along the normal path
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_RESET = 3'h1,
    ST_CMD = 3'h3,
    ST_DATA = 3'h2,
    ST_WAIT_DONE = 3'h6,
    ST_INIT = 3'h7,
    ST_USER = 3'h5,
    ST_ERROR = 3'h4
  } ascl_state_t;

endpackage : ascl_pkg

// ===== ascl_flash_model.sv
// Behavioural serial flash that holds the configuration bitstream
`timescale 1ns/1ps
module ascl_flash_model
(
  // Flash pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_cmd,
  output logic o_data,
  // Bitstream source
  input wire logic [31:0] i_word,
  input wire logic i_bad,
  output logic [7:0] o_index,
  output logic [31:0] o_cmd
);
  int cnt = 0;
  int p;
  logic bit_q = 1'h0;
  // Deselected line shows the inverse of the last bit, never a stale copy
  assign o_data = i_cs_n ? ~bit_q : bit_q;
  assign o_index = (cnt >= 32) ? 8'((cnt - 32) >> 5) : 8'h00;
  always @(negedge i_cs_n) cnt = 0;
  // Command bits taken on the rising edge after each of the first 32 falls
  always @(posedge i_sclk)
    if (!i_cs_n && cnt >= 1 && cnt <= 32)
      o_cmd <= {o_cmd[30:0], i_cmd};
  // One data bit per serial clock, driven on falls from fall 33 on
  always @(negedge i_sclk)
    if (!i_cs_n)
    begin
      p = cnt - 32;
      if (p >= 0)
        bit_q <= i_word[31 - p % 32] ^ (i_bad && o_index == 8'h01 && p % 32 == 31);
      cnt++;
    end
endmodule : ascl_flash_model

// ===== tb_ascl_loader.sv
// Self-checking bench for the serial configuration loader
`timescale 1ns/1ps
module tb_ascl_loader
  import ascl_pkg::*;
;
  logic i_clock = 1'h0, i_reset = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, o_cfg_word, words [0:3], r, addr, seed = 32'h1c;
  logic o_pready, o_pslverr, i_por_delay_select = 1'h0, i_weak_pullup_disable = 1'h0;
  logic [2:0] i_scheme_select = ACTIVE_SERIAL_SCHEME;
  logic i_config_request_n = 1'h1, i_user_startup_clock = 1'h0, i_chain_enable_in_n = 1'h0;
  logic o_chain_enable_out_n, i_config_status_n, o_config_status_n, o_config_status_n_oe;
  logic i_config_complete, o_config_complete, o_config_complete_oe, i_init_complete;
  logic o_init_complete, o_init_complete_oe, o_cfg_serial_clock, o_cfg_serial_clock_oe;
  logic o_flash_chip_select_n, o_flash_chip_select_n_oe, o_cfg_command_out, o_cfg_command_out_oe;
  logic i_cfg_serial_data_in, o_cfg_word_valid, o_user_io_oe, o_weak_pullup_en, o_user_mode;
  logic e, bad = 1'h0, chk = 1'h0;
  logic [7:0] f_idx;
  logic [31:0] f_cmd;
  logic [3:0] ctrls [0:2] = '{4'h4, 4'h3, 4'h0};
  int n, k, err_count = 0, tests_run = 0;
  // Open-drain lines with external pull-ups
  assign i_config_status_n = !o_config_status_n_oe;
  assign i_config_complete = !o_config_complete_oe;
  assign i_init_complete = !o_init_complete_oe;
  ascl_loader #(.POR_STD(200), .POR_FAST(20), .RESTART(30), .INIT_OSC(40), .USER_INIT(20))
    u_ascl_loader (.*);
  ascl_flash_model u_ascl_flash_model (.i_sclk(o_cfg_serial_clock),
    .i_cs_n(o_flash_chip_select_n), .i_cmd(o_cfg_command_out), .o_data(i_cfg_serial_data_in),
    .i_word(words[f_idx[1:0]]), .i_bad(bad), .o_index(f_idx), .o_cmd(f_cmd));
  initial forever #4 i_clock = ~i_clock;
  // User clock well below its limit, offset from the system clock
  initial
  begin
    #3;
    forever #32 i_user_startup_clock = ~i_user_startup_clock;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task complete_run();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task tick(input int lim);
    @(posedge i_clock);
    #1;
    if (++n > lim)
    begin
      check(n, 0);
      complete_run();
    end
  endtask : tick
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'h1, w, a, d};
    @(posedge i_clock);
    i_penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_pready !== 1'h1 && n < 50);
    if (o_pready !== 1'h1)
    begin
      check(n, 0);
      complete_run();
    end
    {r, e} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'h0;
  endtask : apb
  task pulse_req();
    i_config_request_n <= 1'h0;
    repeat (260) @(posedge i_clock);
    #1;
    check({o_config_status_n_oe, o_config_complete_oe, o_user_io_oe}, 3'h6);
    i_config_request_n <= 1'h1;
  endtask : pulse_req
  // Each word loaded while chk is set is compared in order, parity bit set for even parity
  always @(posedge i_clock)
    if (o_cfg_word_valid && chk)
    begin
      check(o_cfg_word, words[k[1:0]]);
      k++;
    end
  task run_pass(input int p);
    addr = rnd();
    i_weak_pullup_disable <= (p == 2);
    apb(1'h1, REG_ADDR, {8'h00, addr[23:0]});
    apb(1'h1, REG_CTRL, {28'h0, ctrls[p]});
    for (int i = 0; i < 4; i++)
    begin
      words[i] = rnd();
      words[i][31] = ^words[i][30:0];
    end
    {bad, chk} = {p != 0, p == 0};
    k = 0;
    if (p == 2)
      i_scheme_select <= 3'h0;
    if (p != 0)
      pulse_req();
    if (p == 2)
    begin
      repeat (20) @(posedge i_clock);
      check(o_flash_chip_select_n, 1'h1);
      i_scheme_select <= ACTIVE_SERIAL_SCHEME;
    end
    n = 0;
    while (o_flash_chip_select_n !== 1'h0) tick(2000);
    check({o_weak_pullup_en, o_config_status_n_oe, o_chain_enable_out_n}, {p != 2, 2'h1});
    check(o_init_complete_oe, 1'h0);
    if (bad)
    begin
      n = 0;
      while (o_config_status_n_oe !== 1'h1) tick(2000);
      check(o_config_complete_oe, 1'h1);
      apb(1'h0, REG_STATUS, 32'h0);
      check(r[STAT_ERROR], 1'h1);
      {bad, chk} = 2'h1;
      n = 0;
      if (ctrls[p][CTRL_AUTO_RESTART])
        while (o_config_status_n_oe !== 1'h0) tick(100);
      else
        pulse_req();
      n = 0;
      while (o_flash_chip_select_n !== 1'h0) tick(2000);
    end
    n = 0;
    while (o_chain_enable_out_n !== 1'h0) tick(2000);
    check({o_init_complete_oe, o_config_complete_oe, o_cfg_serial_clock_oe},
          {ctrls[p][CTRL_INIT_DONE_EN], 2'h0});
    n = 0;
    while (o_user_mode !== 1'h1) tick(5000);
    check(k, 4);
    check(f_cmd, {READ_CMD, addr[23:0]});
    check({o_chain_enable_out_n, o_config_complete_oe, o_init_complete_oe}, 3'h0);
    check({o_user_io_oe, o_weak_pullup_en, o_flash_chip_select_n_oe}, 3'h4);
  endtask : run_pass
  initial
  begin
    repeat (20) @(posedge i_clock);
    check({o_config_status_n_oe, o_config_complete_oe, o_user_io_oe}, 3'h6);
    i_reset <= 1'h0;
    apb(1'h0, REG_CTRL, 32'h0);
    check(r, 32'h0);
    apb(1'h0, REG_WORDS, 32'h0);
    check(r, DEFAULT_WORDS);
    apb(1'h1, 8'h14, 32'hffffffff);
    check(e, 1'h1);
    apb(1'h1, REG_WORDS, 32'h4);
    check({o_config_status_n_oe, o_user_io_oe}, 2'h2);
    for (int p = 0; p < 3; p++)
      run_pass(p);
    // Second reset with the fast delay: 20 cycles, then one for the status register
    i_por_delay_select <= 1'h1;
    i_reset <= 1'h1;
    @(posedge i_clock);
    i_reset <= 1'h0;
    n = 0;
    while (o_config_status_n_oe !== 1'h0) tick(100);
    check(n, 21);
    complete_run();
  end
endmodule : tb_ascl_loader
